/* File: pmp_pkg.sv */
// Constants and types shared by the parallel port mode and timing block
package pmp_pkg;
   // ----------------------------------------
   // Register byte offsets
   // ----------------------------------------
   localparam logic [5:0] OFS_MODE = 6'h00;
   localparam logic [5:0] OFS_ADDR = 6'h04;
   localparam logic [5:0] OFS_DATA = 6'h08;
   localparam logic [5:0] OFS_CTRL = 6'h0C;
   localparam logic [5:0] OFS_OUTBUF = 6'h10;
   localparam logic [5:0] OFS_INBUF = 6'h20;
   // ----------------------------------------
   // Mode register fields, reset values, control bits and sizes
   // ----------------------------------------
   localparam int BUSY_BIT = 15;
   localparam int INTERRUPT_MODE_FIELD_LSB = 13;
   localparam int ADDRESS_STEP_MODE_LSB = 11;
   localparam int PMODE_LSB = 8;
   localparam int SETUP_LSB = 6;
   localparam int STROBE_LSB = 2;
   localparam int HOLD_LSB = 0;
   localparam logic [15:0] MODE_WMASK = 16'h7BFF;
   localparam logic [15:0] MODE_RST = 16'h0000;
   localparam logic [14:0] ADDR_RST = 15'h0000;
   localparam int CTRL_CS_BIT = 0;
   localparam int CTRL_RD_BIT = 1;
   localparam int FIFO_DEPTH = 32;
   localparam int DATA_W = 8;
   // ----------------------------------------
   // Encodings
   // ----------------------------------------
   localparam logic [1:0] IRQ_NONE = 2'h0;
   localparam logic [1:0] IRQ_CYCLE = 2'h1;
   localparam logic [1:0] IRQ_BUF3 = 2'h2;
   localparam logic [1:0] INC_NONE = 2'h0;
   localparam logic [1:0] INC_UP = 2'h1;
   localparam logic [1:0] INC_DOWN = 2'h2;
   localparam logic [1:0] INC_BUF = 2'h3;
   localparam logic [1:0] PM_LEGACY = 2'h0;
   localparam logic [1:0] PM_ENH = 2'h1;
   localparam logic [1:0] PM_MAS2 = 2'h2;
   localparam logic [1:0] PM_MAS1 = 2'h3;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SETUP = 2'b01,
      ST_STROBE = 2'b10,
      ST_HOLD = 2'b11
   } mstate_t;
endpackage : pmp_pkg

/* File: pmp_port.sv */
// Parallel port: data FIFO and mode, addressing and strobe timing engine
// Behaviour
// [R1] Mode bit 15 reads 1 while a master transfer runs, else 0.
// [R2] Interrupt mode 01 pulses the interrupt at each cycle end.
// [R3] Interrupt mode 10 fires on buffer 3 or address 11 slave accesses.
// [R4] Interrupt mode 00 gives none; software never programs 11.
// [R5] Step mode 01 adds one to address bits 10:2 and 14 per cycle.
// [R6] Step mode 10 subtracts one from address bits 10:2 and 14 per cycle.
// [R7] Step mode 11 in legacy slave advances buffer selection per access.
// [R8] Step mode 00 leaves the address unchanged.
// [R9] Address bit 14 used as chip select is never stepped.
// [R10] Port mode 11: master with direction line and enable strobe.
// [R11] Port mode 10: master with separate read and write strobes.
// [R12] Port mode 01: addressed slave, host picks buffer by two lines.
// [R13] Port mode 00: legacy slave, host strobes, no address lines.
// [R14] Setup lasts setup field plus one clocks.
// [R15] Strobe lasts strobe field plus one clocks.
// [R16] Strobe field 0: setup 1, hold 1 on write, 0 on read.
// [R17] Hold lasts hold field plus one clocks before next cycle.
// [R18] Busy sets at start, clears after setup, strobe and hold.
`timescale 1ns/1ns

module pmp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } fifo_st_t;
   fifo_st_t st_r;
   fifo_st_t st_nxt;
   logic push;
   logic pop;

   assign in_ready = st_r.cnt != (AW+1)'(DEPTH);
   assign out_valid = st_r.cnt != '0;
   assign out_data = st_r.mem[st_r.rp];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      st_nxt = st_r;
      if (push) begin
         st_nxt.mem[st_r.wp] = in_data;
         st_nxt.wp = (st_r.wp == AW'(DEPTH - 1)) ? '0 : st_r.wp + 1'b1;
      end
      if (pop) begin
         st_nxt.rp = (st_r.rp == AW'(DEPTH - 1)) ? '0 : st_r.rp + 1'b1;
      end
      st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
endmodule : pmp_fifo

module pmp_port (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic chip_select_out,
   output logic read_strobe,
   output logic write_strobe,
   output logic read_write_direction,
   output logic enable_strobe,
   output logic [14:0] port_address_lines,
   output logic [7:0] port_data_out,
   input wire logic [7:0] port_data_in,
   output logic port_data_oe,
   input wire logic host_read_strobe,
   input wire logic host_write_strobe,
   input wire logic host_chip_select,
   input wire logic [1:0] host_address,
   output logic port_irq
);
   typedef struct packed {
      logic [15:0] mode;
      logic [14:0] addr;
      logic cs_en;
      logic rd_req;
      logic [7:0] rdata;
      logic wait_q;
      logic [31:0] bus_rd;
      pmp_pkg::mstate_t state;
      logic [3:0] cnt;
      logic is_rd;
      logic busy;
      logic irq;
      logic cs;
      logic rds;
      logic wrs;
      logic rwdir;
      logic ens;
      logic [7:0] dout;
      logic doe;
      logic [3:0][7:0] out_buf, in_buf;
      logic [1:0] ridx, widx;
      logic hrd_q, hwr_q;
   } port_st_t;
   port_st_t st_r;
   port_st_t st_nxt;
   logic fin_ready;
   logic fout_valid;
   logic fout_ready;
   logic [7:0] fout_data;
   logic fpush;
   logic cfg_wr;

   // ----------------------------------------
   // Data FIFO between bus writes and master cycles
   // ----------------------------------------
   pmp_fifo #(
      .WIDTH(pmp_pkg::DATA_W),
      .DEPTH(pmp_pkg::FIFO_DEPTH)
   ) u_fifo (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .in_valid(fpush),
      .in_ready(fin_ready),
      .in_data(avs_writedata[7:0]),
      .out_valid(fout_valid),
      .out_ready(fout_ready),
      .out_data(fout_data)
   );

   // Pop only when idle, no read queued and no mode or address write pending
   assign fout_ready = st_r.mode[pmp_pkg::PMODE_LSB+1] && st_r.state == pmp_pkg::ST_IDLE
      && !st_r.rd_req && !cfg_wr;
   assign fpush = avs_write && !st_r.wait_q && avs_address == pmp_pkg::OFS_DATA;
   // A cycle started under a landing mode write would mix old and new timing
   assign cfg_wr = avs_write
      && (avs_address == pmp_pkg::OFS_MODE || avs_address == pmp_pkg::OFS_ADDR);

   always_comb begin
      logic [1:0] interrupt_mode_field, address_step_mode, pmode;
      logic [3:0] wm;
      logic [15:0] wmask;
      logic ok, start, fin;
      logic [2:0] hold_len;
      logic [9:0] s10;
      logic cur_rd, cur_wr;
      logic [1:0] sidx_r, sidx_w;
      interrupt_mode_field = st_r.mode[pmp_pkg::INTERRUPT_MODE_FIELD_LSB +: 2];
      address_step_mode = st_r.mode[pmp_pkg::ADDRESS_STEP_MODE_LSB +: 2];
      pmode = st_r.mode[pmp_pkg::PMODE_LSB +: 2];
      wm = st_r.mode[pmp_pkg::STROBE_LSB +: 4];
      wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
      ok = 1'b1;
      start = 1'b0;
      fin = 1'b0;
      hold_len = 3'h0;
      s10 = {st_r.addr[14], st_r.addr[10:2]};
      cur_rd = host_read_strobe && host_chip_select;
      cur_wr = host_write_strobe && host_chip_select;
      sidx_r = (pmode == pmp_pkg::PM_ENH) ? host_address :
         (address_step_mode == pmp_pkg::INC_BUF) ? st_r.ridx : 2'h0;
      sidx_w = (pmode == pmp_pkg::PM_ENH) ? host_address :
         (address_step_mode == pmp_pkg::INC_BUF) ? st_r.widx : 2'h0;
      st_nxt = st_r;
      st_nxt.irq = 1'b0;
      st_nxt.wait_q = 1'b1;

      // ----------------------------------------
      // Bus slave: one wait cycle, more while a write stalls, then answer
      // ----------------------------------------
      // Config writes stall while busy so timing never changes mid-cycle
      unique case (avs_address)
         pmp_pkg::OFS_MODE, pmp_pkg::OFS_ADDR: ok = !(avs_write && st_r.busy);
         pmp_pkg::OFS_DATA: ok = !avs_write || fin_ready;
         pmp_pkg::OFS_CTRL: ok = !(avs_write && st_r.rd_req);
         default: ok = 1'b1;
      endcase
      if ((avs_read || avs_write) && st_r.wait_q && ok) begin
         st_nxt.wait_q = 1'b0;
         st_nxt.bus_rd = 32'h0000_0000;
         if (avs_read) begin
            if (avs_address == pmp_pkg::OFS_MODE) begin
               st_nxt.bus_rd = {16'h0000, st_r.busy, st_r.mode[14:0]}; // [R1]
            end else if (avs_address == pmp_pkg::OFS_ADDR) begin
               st_nxt.bus_rd = {17'h00000, st_r.addr};
            end else if (avs_address == pmp_pkg::OFS_DATA) begin
               st_nxt.bus_rd = {24'h000000, st_r.rdata};
            end else if (avs_address == pmp_pkg::OFS_CTRL) begin
               st_nxt.bus_rd = {30'h00000000, st_r.rd_req, st_r.cs_en};
            end else if (avs_address[5:4] == 2'h1 && avs_address[1:0] == 2'h0) begin
               st_nxt.bus_rd = {24'h000000, st_r.out_buf[avs_address[3:2]]};
            end else if (avs_address[5:4] == 2'h2 && avs_address[1:0] == 2'h0) begin
               st_nxt.bus_rd = {24'h000000, st_r.in_buf[avs_address[3:2]]};
            end
         end
      end
      if (avs_write && !st_r.wait_q) begin
         if (avs_address == pmp_pkg::OFS_MODE) begin
            st_nxt.mode = (st_r.mode & ~(wmask & pmp_pkg::MODE_WMASK))
               | (avs_writedata[15:0] & wmask & pmp_pkg::MODE_WMASK);
         end else if (avs_address == pmp_pkg::OFS_ADDR) begin
            if (avs_byteenable[0]) st_nxt.addr[7:0] = avs_writedata[7:0];
            if (avs_byteenable[1]) st_nxt.addr[14:8] = avs_writedata[14:8];
         end else if (avs_address == pmp_pkg::OFS_CTRL && avs_byteenable[0]) begin
            st_nxt.cs_en = avs_writedata[pmp_pkg::CTRL_CS_BIT];
            st_nxt.rd_req = avs_writedata[pmp_pkg::CTRL_RD_BIT];
         end else if (avs_address[5:4] == 2'h1 && avs_address[1:0] == 2'h0
            && avs_byteenable[0]) begin
            st_nxt.out_buf[avs_address[3:2]] = avs_writedata[7:0];
         end
      end

      // ----------------------------------------
      // Master engine
      // ----------------------------------------
      unique case (st_r.state)
         pmp_pkg::ST_IDLE: begin
            if (pmode[1] && !cfg_wr && (st_r.rd_req || fout_valid)) begin
               start = 1'b1;
               st_nxt.is_rd = st_r.rd_req;
               st_nxt.rd_req = 1'b0;
               st_nxt.dout = fout_data;
               st_nxt.doe = !st_r.rd_req;
               st_nxt.rwdir = st_r.rd_req;
            end
         end
         pmp_pkg::ST_SETUP: begin
            if (st_r.cnt == 4'h0) begin
               st_nxt.state = pmp_pkg::ST_STROBE;
               st_nxt.cnt = wm; // [R15]
               st_nxt.ens = pmode == pmp_pkg::PM_MAS1; // [R10]
               st_nxt.rds = pmode == pmp_pkg::PM_MAS2 && st_r.is_rd; // [R11]
               st_nxt.wrs = pmode == pmp_pkg::PM_MAS2 && !st_r.is_rd; // [R11]
            end else begin
               st_nxt.cnt = st_r.cnt - 4'h1;
            end
         end
         pmp_pkg::ST_STROBE: begin
            if (st_r.cnt == 4'h0) begin
               st_nxt.ens = 1'b0;
               st_nxt.rds = 1'b0;
               st_nxt.wrs = 1'b0;
               if (st_r.is_rd) st_nxt.rdata = port_data_in;
               if (wm == 4'h0) begin
                  hold_len = st_r.is_rd ? 3'h0 : 3'h1; // [R16]
               end else begin
                  hold_len = {1'b0, st_r.mode[pmp_pkg::HOLD_LSB +: 2]} + 3'h1; // [R17]
               end
               if (hold_len == 3'h0) begin
                  fin = 1'b1;
               end else begin
                  st_nxt.state = pmp_pkg::ST_HOLD;
                  st_nxt.cnt = 4'(hold_len - 3'h1);
               end
            end else begin
               st_nxt.cnt = st_r.cnt - 4'h1;
            end
         end
         pmp_pkg::ST_HOLD: begin
            if (st_r.cnt == 4'h0) fin = 1'b1;
            else st_nxt.cnt = st_r.cnt - 4'h1;
         end
      endcase
      if (start) begin
         st_nxt.state = pmp_pkg::ST_SETUP;
         st_nxt.busy = 1'b1; // [R18]
         st_nxt.cs = st_r.cs_en;
         // Zero strobe wait forces a single setup clock
         st_nxt.cnt = (wm == 4'h0) ? 4'h0 : {2'h0, st_r.mode[pmp_pkg::SETUP_LSB +: 2]}; // [R14] [R16]
      end
      if (fin) begin
         st_nxt.state = pmp_pkg::ST_IDLE;
         st_nxt.busy = 1'b0; // [R18]
         st_nxt.cs = 1'b0;
         st_nxt.doe = 1'b0;
         st_nxt.irq = interrupt_mode_field == pmp_pkg::IRQ_CYCLE; // [R2] [R4]
         if (address_step_mode == pmp_pkg::INC_UP) begin
            if (st_r.cs_en) st_nxt.addr[10:2] = st_r.addr[10:2] + 9'h001; // [R9]
            else {st_nxt.addr[14], st_nxt.addr[10:2]} = s10 + 10'h001; // [R5]
         end else if (address_step_mode == pmp_pkg::INC_DOWN) begin
            if (st_r.cs_en) st_nxt.addr[10:2] = st_r.addr[10:2] - 9'h001; // [R9]
            else {st_nxt.addr[14], st_nxt.addr[10:2]} = s10 - 10'h001; // [R6]
         end // [R8]
      end

      // ----------------------------------------
      // Slave modes: host owns the strobes
      // ----------------------------------------
      st_nxt.hrd_q = cur_rd;
      st_nxt.hwr_q = cur_wr;
      if (!pmode[1]) begin
         // Bus driven only while the host reads, a clock late
         st_nxt.doe = cur_rd; // [R12] [R13]
         st_nxt.dout = st_r.out_buf[sidx_r];
         if (st_r.hwr_q && !cur_wr) begin
            st_nxt.in_buf[sidx_w] = port_data_in; // [R12] [R13]
         end
         if ((st_r.hrd_q && !cur_rd) || (st_r.hwr_q && !cur_wr)) begin
            if (interrupt_mode_field == pmp_pkg::IRQ_CYCLE) begin
               st_nxt.irq = 1'b1; // [R2]
            end else if (interrupt_mode_field == pmp_pkg::IRQ_BUF3) begin
               st_nxt.irq = ((st_r.hrd_q && !cur_rd) ? sidx_r : sidx_w) == 2'h3
                  && (pmode == pmp_pkg::PM_ENH || address_step_mode == pmp_pkg::INC_BUF); // [R3]
            end
         end
         if (pmode == pmp_pkg::PM_LEGACY && address_step_mode == pmp_pkg::INC_BUF) begin
            if (st_r.hrd_q && !cur_rd) st_nxt.ridx = st_r.ridx + 2'h1; // [R7]
            if (st_r.hwr_q && !cur_wr) st_nxt.widx = st_r.widx + 2'h1; // [R7]
         end
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_r <= '0;
         st_r.mode <= pmp_pkg::MODE_RST;
         st_r.addr <= pmp_pkg::ADDR_RST;
         st_r.wait_q <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign avs_readdata = st_r.bus_rd;
   assign avs_waitrequest = st_r.wait_q;
   assign chip_select_out = st_r.cs;
   assign read_strobe = st_r.rds;
   assign write_strobe = st_r.wrs;
   assign read_write_direction = st_r.rwdir;
   assign enable_strobe = st_r.ens;
   assign port_address_lines = st_r.addr;
   assign port_data_out = st_r.dout;
   assign port_data_oe = st_r.doe;
   assign port_irq = st_r.irq;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   logic [4:0] phase_cnt;
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) phase_cnt <= 5'h01;
      else if (st_nxt.state != st_r.state) phase_cnt <= 5'h01;
      else if (phase_cnt != 5'h1F) phase_cnt <= phase_cnt + 5'h01;
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   busy_flag_a: assert property ((st_r.state != pmp_pkg::ST_IDLE) == st_r.busy) // [R1]
      else $error("busy flag disagrees with engine state");
   irq_cycle_a: assert property ($fell(st_r.busy) && st_r.mode[14:13] == 2'h1 |-> port_irq) // [R2]
      else $error("no interrupt at cycle end");
   irq_off_a: assert property ($past(st_r.mode[14:13]) == 2'h0 |-> !port_irq) // [R4]
      else $error("interrupt while disabled");
   step_up_a: assert property ($fell(st_r.busy) && st_r.mode[12:11] == 2'h1 && !st_r.cs_en // [R5]
      |-> {st_r.addr[14], st_r.addr[10:2]} == 10'($past({st_r.addr[14], st_r.addr[10:2]}) + 1))
      else $error("address not incremented");
   step_down_a: assert property ($fell(st_r.busy) && st_r.mode[12:11] == 2'h2 && !st_r.cs_en // [R6]
      |-> {st_r.addr[14], st_r.addr[10:2]} == 10'($past({st_r.addr[14], st_r.addr[10:2]}) - 1))
      else $error("address not decremented");
   addr_still_a: assert property ($fell(st_r.busy) && st_r.mode[12:11] == 2'h0 |-> $stable(st_r.addr)) // [R8]
      else $error("address moved in no-step mode");
   cs_bit_a: assert property ($fell(st_r.busy) && st_r.cs_en |-> $stable(st_r.addr[14])) // [R9]
      else $error("chip select bit stepped");
   setup_len_a: assert property ($past(st_r.state) == pmp_pkg::ST_SETUP // [R14]
      && st_r.state == pmp_pkg::ST_STROBE |-> $past(phase_cnt) ==
      ((st_r.mode[5:2] == 4'h0) ? 5'h01 : {3'h0, st_r.mode[7:6]} + 5'h01))
      else $error("wrong setup length");
   strobe_len_a: assert property ($past(st_r.state) == pmp_pkg::ST_STROBE // [R15]
      && st_r.state != pmp_pkg::ST_STROBE |-> $past(phase_cnt) == {1'b0, st_r.mode[5:2]} + 5'h01)
      else $error("wrong strobe length");
   hold_read_a: assert property ($fell(read_strobe) && st_r.mode[5:2] == 4'h0 // [R16]
      |-> !st_r.busy)
      else $error("read hold not zero");
   hold_len_a: assert property ($past(st_r.state) == pmp_pkg::ST_HOLD // [R17]
      && st_r.state == pmp_pkg::ST_IDLE && st_r.mode[5:2] != 4'h0
      |-> $past(phase_cnt) == {3'h0, st_r.mode[1:0]} + 5'h01)
      else $error("wrong hold length");
   legacy_adv_a: assert property (st_r.mode[9:8] == 2'h0 && st_r.mode[12:11] == 2'h3 // [R7]
      && st_r.hwr_q && !(host_write_strobe && host_chip_select) |=> st_r.widx == $past(st_r.widx) + 2'h1)
      else $error("write buffer index not advanced");
endmodule : pmp_port

/* File: pmp_peer.sv */
// Model of the external parallel device facing the master port
`timescale 1ns/1ns

module pmp_peer (
   input wire logic sys_clk,
   input wire logic read_strobe,
   input wire logic write_strobe,
   input wire logic read_write_direction,
   input wire logic enable_strobe,
   input wire logic [14:0] port_address_lines,
   input wire logic [7:0] port_data_out,
   input wire logic port_data_oe,
   output logic [7:0] peer_data
);
   logic [7:0] wr_q[$];
   logic [7:0] last_r = 8'h00;
   logic wr_act_r = 1'b0;
   logic rd_act;
   logic wr_act;
   assign rd_act = read_strobe | (enable_strobe & read_write_direction);
   assign wr_act = write_strobe | (enable_strobe & ~read_write_direction);
   // Released bus shows the inverse of the last byte, so stale data never matches
   assign peer_data = rd_act ? (port_address_lines[7:0] ^ 8'h5A) : ~last_r;
   always @(posedge sys_clk) begin
      if (rd_act) begin
         last_r <= peer_data;
      end
      if (wr_act && !wr_act_r && port_data_oe) begin
         wr_q.push_back(port_data_out);
      end
      wr_act_r <= wr_act;
   end
endmodule : pmp_peer

/* File: tb.sv */
// Self-checking testbench of the parallel port block
`timescale 1ns/1ns
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
   $display("[ERR] %s exp %h got %h", nm, e, g); end end

module tb;
   typedef struct packed {
      logic [1:0] pm;
      logic [1:0] s;
      logic [3:0] m;
      logic [1:0] h;
   } row_t;
   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   logic [5:0] avs_address = 6'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hF;
   logic [31:0] avs_readdata;
   logic avs_waitrequest, chip_select_out, read_strobe, write_strobe, read_write_direction;
   logic enable_strobe, port_data_oe, port_irq;
   logic [14:0] port_address_lines;
   logic [7:0] port_data_out, port_data_in, peer_data;
   logic host_read_strobe = 1'b0, host_write_strobe = 1'b0, host_chip_select = 1'b0;
   logic [1:0] host_address = 2'h0;
   logic [7:0] host_data = 8'h00;
   logic host_mode = 1'b0;
   logic [31:0] rq;
   logic [31:0] mw;
   logic [7:0] pb;
   int mismatches = 0, samples_checked = 0, irq_n = 0, rn, mx, base, oe_n, ws_n, rs_n, en_n, cs_n;
   row_t rows[5] = '{10'h200, 10'h3C2, 10'h204, 10'h3FF, 10'h256};

   always #25 sys_clk = ~sys_clk;
   assign port_data_in = host_mode ? host_data : peer_data;
   always @(posedge sys_clk) if (port_irq === 1'b1) irq_n++;

   pmp_port i_pmp_port (.sys_clk, .arst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .chip_select_out, .read_strobe,
      .write_strobe, .read_write_direction, .enable_strobe, .port_address_lines, .port_data_out,
      .port_data_in, .port_data_oe, .host_read_strobe, .host_write_strobe, .host_chip_select,
      .host_address, .port_irq);
   pmp_peer i_pmp_peer (.sys_clk, .read_strobe, .write_strobe, .read_write_direction,
      .enable_strobe, .port_address_lines, .port_data_out, .port_data_oe, .peer_data);

   // ----------------------------------------
   // Bus and port tasks
   // ----------------------------------------
   task automatic finish_test;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : finish_test

   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      rn = 0;
      do begin
         @(posedge sys_clk);
         rn++;
      end while (avs_waitrequest !== 1'b0 && rn < 2000);
      rq = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (rn >= 2000) begin
         mismatches++;
         finish_test();
      end
   endtask : bus

   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr

   task automatic rd(input logic [5:0] a);
      bus(1'b0, a, 32'h0);
   endtask : rd

   function automatic logic [31:0] mword(input logic [1:0] irq, input logic [1:0] inc,
      input logic [1:0] pm, input logic [7:0] lo);
      return {16'h0, 1'b0, irq, inc, 1'b0, pm, lo};
   endfunction : mword

   task automatic watch(input int cyc);
      oe_n = 0;
      ws_n = 0;
      rs_n = 0;
      en_n = 0;
      cs_n = 0;
      repeat (cyc) begin
         @(posedge sys_clk);
         oe_n += port_data_oe;
         ws_n += write_strobe;
         rs_n += read_strobe;
         en_n += enable_strobe;
         cs_n += chip_select_out;
      end
   endtask : watch

   task automatic rstep(input logic [31:0] m, input logic [31:0] c, input logic [31:0] a0,
      input logic [31:0] ae);
      wr(pmp_pkg::OFS_MODE, m);
      wr(pmp_pkg::OFS_ADDR, a0);
      wr(pmp_pkg::OFS_CTRL, c);
      watch(20);
      `CHK("rd_strobe", m[9:8] == 2'h2, rs_n)
      `CHK("en_strobe", m[9:8] == 2'h3, en_n)
      `CHK("rd_no_oe", 0, oe_n)
      `CHK("cs_len", c[0] ? 2 : 0, cs_n)
      rd(pmp_pkg::OFS_DATA);
      `CHK("rd_data", {24'h0, a0[7:0] ^ 8'h5A}, rq)
      rd(pmp_pkg::OFS_ADDR);
      `CHK("addr_step", ae, rq)
   endtask : rstep

   // Host side: strobes held two cycles; data released to its inverse afterwards
   task automatic hs(input logic w, input logic [1:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      host_mode <= 1'b1;
      host_address <= a;
      host_data <= d;
      host_chip_select <= 1'b1;
      host_write_strobe <= w;
      host_read_strobe <= !w;
      repeat (2) @(posedge sys_clk);
      if (!w) begin
         `CHK("host_rd", {1'b1, d}, {port_data_oe, port_data_out})
      end
      host_write_strobe <= 1'b0;
      host_read_strobe <= 1'b0;
      host_chip_select <= 1'b0;
      repeat (2) @(posedge sys_clk);
      host_data <= ~d;
      repeat (2) @(posedge sys_clk);
   endtask : hs

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (6) @(posedge sys_clk);
      `CHK("wait_rst", 4'h8, {avs_waitrequest, port_data_oe, port_irq, chip_select_out})
      arst_n <= 1'b1;
      rd(pmp_pkg::OFS_MODE);
      `CHK("mode_rst", 32'h0, rq)
      foreach (rows[i]) begin
         mw = mword(pmp_pkg::IRQ_CYCLE, pmp_pkg::INC_NONE, rows[i].pm, rows[i][7:0]);
         wr(pmp_pkg::OFS_MODE, mw);
         rd(pmp_pkg::OFS_MODE);
         `CHK("mode_rb", mw, rq)
         wr(pmp_pkg::OFS_ADDR, 32'h0123);
         base = irq_n;
         wr(pmp_pkg::OFS_DATA, 8'hC0 + i);
         watch(40);
         `CHK("oe_len", rows[i].m == 0 ? 3 : rows[i].s + rows[i].m + rows[i].h + 3, oe_n)
         `CHK("wr_strobe", rows[i].pm == 2'h2 ? rows[i].m + 1 : 0, ws_n)
         `CHK("en_strobe", rows[i].pm == 2'h3 ? rows[i].m + 1 : 0, en_n)
         `CHK("irq_cycle", 1, irq_n - base)
         pb = i_pmp_peer.wr_q.pop_front();
         `CHK("peer_byte", 8'hC0 + i, pb)
         rd(pmp_pkg::OFS_ADDR);
         `CHK("addr_hold", 32'h0123, rq)
      end
      // Slow cycles so the buffer fills ahead of the port
      wr(pmp_pkg::OFS_MODE, mword(pmp_pkg::IRQ_NONE, pmp_pkg::INC_NONE, pmp_pkg::PM_MAS2, 8'hFF));
      base = irq_n;
      wr(pmp_pkg::OFS_DATA, 8'hEE);
      rd(pmp_pkg::OFS_MODE);
      `CHK("busy_set", 1'b1, rq[15])
      watch(30);
      rd(pmp_pkg::OFS_MODE);
      `CHK("busy_clr", 1'b0, rq[15])
      mx = 0;
      for (int i = 0; i < 40; i++) begin
         wr(pmp_pkg::OFS_DATA, i);
         if (rn > mx) mx = rn;
      end
      `CHK("fifo_stall", 1'b1, mx > 2)
      watch(1000);
      `CHK("irq_none", base, irq_n)
      `CHK("drain_cnt", 41, i_pmp_peer.wr_q.size())
      for (int i = -1; i < 40; i++) begin
         pb = i_pmp_peer.wr_q.pop_front();
         `CHK("fifo_order", i < 0 ? 8'hEE : 8'(i), pb)
      end
      rstep(mword(pmp_pkg::IRQ_CYCLE, pmp_pkg::INC_UP, pmp_pkg::PM_MAS1, 8'h00), 32'h2, 32'h07FC, 32'h4000);
      rstep(mword(pmp_pkg::IRQ_CYCLE, pmp_pkg::INC_DOWN, pmp_pkg::PM_MAS2, 8'h00), 32'h2, 32'h4000, 32'h07FC);
      rstep(mword(pmp_pkg::IRQ_CYCLE, pmp_pkg::INC_UP, pmp_pkg::PM_MAS1, 8'h00), 32'h3, 32'h07FC, 32'h0000);
      wr(6'h30, 32'hFF);
      rd(6'h30);
      `CHK("unmapped", 32'h0, rq)
      wr(pmp_pkg::OFS_MODE, 32'hFFFF85FF);
      rd(pmp_pkg::OFS_MODE);
      `CHK("mode_rsvd", 32'h000001FF, rq)
      wr(pmp_pkg::OFS_MODE, mword(pmp_pkg::IRQ_BUF3, pmp_pkg::INC_NONE, pmp_pkg::PM_ENH, 8'h00));
      wr(pmp_pkg::OFS_OUTBUF, 32'h3C);
      hs(1'b0, 2'h0, 8'h3C);
      base = irq_n;
      hs(1'b1, 2'h3, 8'hA5);
      hs(1'b1, 2'h1, 8'h11);
      `CHK("irq_addr3", 1, irq_n - base)
      rd(pmp_pkg::OFS_INBUF + 6'h0C);
      `CHK("inbuf3", 32'hA5, rq)
      wr(pmp_pkg::OFS_MODE, mword(pmp_pkg::IRQ_BUF3, pmp_pkg::INC_BUF, pmp_pkg::PM_LEGACY, 8'h00));
      base = irq_n;
      for (int i = 0; i < 4; i++) hs(1'b1, 2'h0, 8'(8'h21 + i));
      `CHK("irq_buf3", 1, irq_n - base)
      for (int i = 0; i < 4; i++) begin
         rd(pmp_pkg::OFS_INBUF + 6'(4 * i));
         `CHK("legacy_buf", 32'h21 + i, rq)
      end
      wr(pmp_pkg::OFS_OUTBUF + 6'h04, 32'h5D);
      wr(pmp_pkg::OFS_MODE, mword(pmp_pkg::IRQ_CYCLE, pmp_pkg::INC_BUF, pmp_pkg::PM_LEGACY, 8'h00));
      base = irq_n;
      hs(1'b0, 2'h0, 8'h3C);
      hs(1'b0, 2'h0, 8'h5D);
      `CHK("irq_slave", 2, irq_n - base)
      wr(pmp_pkg::OFS_MODE, mword(pmp_pkg::IRQ_NONE, pmp_pkg::INC_BUF, pmp_pkg::PM_LEGACY, 8'h00));
      base = irq_n;
      for (int i = 0; i < 4; i++) hs(1'b1, 2'h0, 8'h40);
      `CHK("irq_off", base, irq_n)
      finish_test();
   end
endmodule : tb
